// >>> bench/dda_link_properties.sv
// Concurrent checks on the converter link and the converter-side outputs
`timescale 1ns/1ps
`default_nettype none
module dda_link_properties (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic DUAL_BUS_MODE,
  input wire logic [dda_pkg::CODE_W-1:0] chan_a_data,
  input wire logic [dda_pkg::CODE_W-1:0] chan_b_data,
  input wire logic chan_a_write_strobe,
  input wire logic chan_b_write_strobe,
  input wire logic chan_a_update_clock,
  input wire logic chan_b_update_clock,
  input wire logic channel_select,
  input wire logic pairing_reset,
  input wire logic [dda_pkg::CODE_W-1:0] CODE_A,
  input wire logic UPDATE_A,
  input wire logic UPDATE_B,
  input wire logic DIV_CLK
);
  import dda_pkg::*;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SRST);

  ////////////////////////////////////////////////////////////////////////////////
  strobe_clock_tied_a: assert property (
    chan_a_write_strobe == chan_a_update_clock && chan_b_write_strobe == chan_b_update_clock)
    else $error("strobe and update clock lines differ");
  data_stable_write_a: assert property (
    $rose(chan_a_write_strobe) |-> $stable(chan_a_data) && $stable(chan_b_data) && $stable(channel_select))
    else $error("link data moved on a write edge");
  dual_step_a: assert property (
    DUAL_BUS_MODE && $rose(chan_a_update_clock) |-> ##[2:6] (UPDATE_A && UPDATE_B))
    else $error("update clock rise did not step the pipelines");
  update_pulse_a: assert property (
    UPDATE_A |=> !UPDATE_A)
    else $error("update pulse longer than one cycle");
  code_moves_step_a: assert property (
    !$stable(CODE_A) |-> UPDATE_A || $past(UPDATE_A))
    else $error("converter code changed without a pipeline step");
  // Default half period of 4 gives 8 high and 8 low cycles
  div_by_two_a: assert property (
    !DUAL_BUS_MODE && $rose(DIV_CLK) |-> DIV_CLK[*8] ##1 !DIV_CLK[*8] ##1 DIV_CLK)
    else $error("divided clock period wrong");
  div_held_low_a: assert property (
    pairing_reset[*6] |-> !DIV_CLK)
    else $error("divided clock ran during pairing reset");
  dual_no_div_a: assert property (
    DUAL_BUS_MODE && $stable(DUAL_BUS_MODE) |-> !DIV_CLK)
    else $error("divided clock active in dual mode");
  select_alternates_a: assert property (
    !DUAL_BUS_MODE && !pairing_reset && $fell(chan_a_write_strobe) |-> channel_select != $past(channel_select))
    else $error("channel select did not alternate");
  pair_release_a: assert property (
    $fell(pairing_reset) |-> channel_select && $fell(chan_a_write_strobe))
    else $error("pairing reset released off an A word step");

  cover property (!DUAL_BUS_MODE && $rose(DIV_CLK));
  cover property (DUAL_BUS_MODE && UPDATE_B);
  cover property ($fell(pairing_reset));
endmodule
`default_nettype wire

// >>> bench/dual_dac_input_interface_tb_top.sv
// Self-checking bench: source and converter ends joined over the link
`timescale 1ns/1ps
`default_nettype none
module dual_dac_input_interface_tb_top;
  import dda_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic dual_mode = 1'b0;
  logic s_valid = 1'b0;
  logic [2*CODE_W-1:0] s_data = 20'h0_0000;
  logic s_ready;
  logic [CODE_W-1:0] code_a;
  logic [CODE_W-1:0] code_b;
  logic upd_a;
  logic upd_b;
  logic div_clk;
  logic [CODE_W-1:0] prev_a = 10'h000;
  logic [CODE_W-1:0] prev_b = 10'h000;
  logic [CODE_W-1:0] exp_a[$];
  logic [CODE_W-1:0] exp_b[$];
  int errors = 0;
  int comparisons = 0;
  int stalls;

  dda_link_if dda_link_if_i ();
  dda_src_end dda_src_end_i (.CLK_SYS(clk_sys), .SRST(srst), .DUAL_BUS_MODE(dual_mode), .S_VALID(s_valid),
    .S_READY(s_ready), .S_DATA(s_data), .link(dda_link_if_i));
  dda_dev_end dda_dev_end_i (.CLK_SYS(clk_sys), .SRST(srst), .DUAL_BUS_MODE(dual_mode), .link(dda_link_if_i),
    .CODE_A(code_a), .CODE_B(code_b), .UPDATE_A(upd_a), .UPDATE_B(upd_b), .DIV_CLK(div_clk));
  dda_link_properties dda_link_properties_i (.CLK_SYS(clk_sys), .SRST(srst), .DUAL_BUS_MODE(dual_mode),
    .chan_a_data(dda_link_if_i.chan_a_data), .chan_b_data(dda_link_if_i.chan_b_data),
    .chan_a_write_strobe(dda_link_if_i.chan_a_write_strobe),
    .chan_b_write_strobe(dda_link_if_i.chan_b_write_strobe),
    .chan_a_update_clock(dda_link_if_i.chan_a_update_clock),
    .chan_b_update_clock(dda_link_if_i.chan_b_update_clock),
    .channel_select(dda_link_if_i.channel_select), .pairing_reset(dda_link_if_i.pairing_reset),
    .CODE_A(code_a), .UPDATE_A(upd_a), .UPDATE_B(upd_b), .DIV_CLK(div_clk));

  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [CODE_W-1:0] seen, input logic [CODE_W-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Corner words first, then random; never zero or a repeat, so every word shows as a change
  function automatic logic [CODE_W-1:0] pick(input logic [CODE_W-1:0] last, input int i);
    logic [CODE_W-1:0] w;
    w = (i == 0) ? 10'h3ff : (i == 1) ? 10'h001 : (i == 2) ? 10'h200 : CODE_W'($urandom);
    if (w == last || w == 10'h000) w = (last == 10'h3ff) ? 10'h001 : last + 1'b1;
    return w;
  endfunction

  // Every change of a code must be the next word sent on that channel
  always @(negedge clk_sys) begin
    if (!srst && code_a !== prev_a) begin
      if (exp_a.size() == 0) check("code_a extra", code_a, ~code_a);
      else check("code_a", code_a, exp_a.pop_front());
    end
    if (!srst && code_b !== prev_b) begin
      if (exp_b.size() == 0) check("code_b extra", code_b, ~code_b);
      else check("code_b", code_b, exp_b.pop_front());
    end
    prev_a <= code_a;
    prev_b <= code_b;
  end

  // Counts update clock rises from the write of w until w reaches the output
  task automatic measure(input logic [CODE_W-1:0] w);
    int n;
    int k;
    logic last;
    n = -1;
    k = 0;
    last = 1'b1;
    while (code_a !== w && k < 2000) begin
      @(negedge clk_sys);
      k++;
      if (dda_link_if_i.chan_a_update_clock && !last && (n >= 0 || dda_link_if_i.chan_a_data === w)) n++;
      last = dda_link_if_i.chan_a_update_clock;
    end
    check("latency", CODE_W'(n), CODE_W'(LAT_CLKS));
  endtask

  task automatic run_test(input logic dual, input int n);
    logic [CODE_W-1:0] wa;
    logic [CODE_W-1:0] wb;
    int k;
    srst <= 1'b1;
    dual_mode <= dual;
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    wa = 10'h000;
    wb = 10'h000;
    stalls = 0;
    fork
      measure(10'h3ff);
    join_none
    for (int i = 0; i < n; i++) begin
      wa = pick(wa, i);
      wb = pick(wb, i + 1);
      exp_a.push_back(wa);
      exp_b.push_back(wb);
      s_valid <= 1'b1;
      s_data <= {wb, wa};
      k = 0;
      do begin
        @(posedge clk_sys);
        k++;
        if (s_ready !== 1'b1 && i > 0) stalls++;
      end while (s_ready !== 1'b1 && k < 1000);
      check("s_ready", CODE_W'(s_ready === 1'b1), 10'h001);
    end
    s_valid <= 1'b0;
    check("fifo refused", CODE_W'(stalls > 0), 10'h001);
    k = 0;
    while ((exp_a.size() != 0 || exp_b.size() != 0) && k < 3000) begin
      @(posedge clk_sys);
      k++;
    end
    // Drained: codes must now hold the last pair
    repeat (64) @(posedge clk_sys);
    check("words pending", CODE_W'(exp_a.size() + exp_b.size()), 10'h000);
    $display("test dual=%0d done, errors %0d", dual, errors);
  endtask

  initial begin
    void'($urandom(32'h0000_861d));
    run_test(1'b0, 24);
    run_test(1'b1, 24);
    final_report();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    final_report();
  end
endmodule
`default_nettype wire

// >>> hdl/dda_dev_end.sv
// Converter-side input front end: latches, pairing and converter pipelines
//
// Contract
// - 10-bit straight binary, bit 9 MSB
// - Mode low interleaved, high dual bus
// - Dual mode: per-channel bus, strobe, clock
// - Dual: rising strobe loads input latch
// - Dual: update clock moves latch to converter
// - Source: clock edge not after write
// - Source: late clock at least 2 ns
// - Source: tie strobe and clock together
// - Four clock latency strobe to output
// - Interleaved: words on A bus only
// - Interleaved: shared strobe, shared clock, divided
// - Select high to A, low to B
// - Select high: B latch recirculates
// - Source: A bus at twice update rate
// - Rising shared strobe captures each word
// - Falling shared strobe presents to converter
// - Shared clock divided by two
// - Divided clock low during pairing reset
// - Pairing reset fixes divided clock phase
`timescale 1ns/1ps
`default_nettype none
module dda_dev_end #(
  parameter int LAT = dda_pkg::LAT_CLKS
) (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic DUAL_BUS_MODE,
  dda_link_if.dev link,
  output logic [dda_pkg::CODE_W-1:0] CODE_A,
  output logic [dda_pkg::CODE_W-1:0] CODE_B,
  output logic UPDATE_A,
  output logic UPDATE_B,
  output logic DIV_CLK
);
  import dda_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration check

  generate
    if (LAT < 2 || (LAT % 2) != 0) begin : g_bad_lat
      $error("LAT must be even and at least 2");
    end
  endgenerate

  localparam int HALF_LAT = LAT / 2;

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling

  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] sync1_reg;
  logic [PIN_W-1:0] sync2_reg;
  logic [PIN_W-1:0] sync3_reg;
  logic [PIN_W-1:0] stable_reg;
  logic [PIN_W-1:0] agree;
  logic [PIN_W-1:0] stable_next;
  logic [PIN_W-1:0] rise;
  logic [PIN_W-1:0] fall;

  // B bus is sampled in both modes but only dual mode reads it
  assign pin_raw = {link.chan_b_data, link.chan_a_data, link.pairing_reset, link.channel_select,
                    link.chan_b_update_clock, link.chan_a_update_clock,
                    link.chan_b_write_strobe, link.chan_a_write_strobe};

  // A change counts only once stages two and three agree
  assign agree = ~(sync2_reg ^ sync3_reg);
  assign stable_next = (agree & sync3_reg) | (~agree & stable_reg);
  assign rise = agree & sync3_reg & ~stable_reg;
  assign fall = agree & ~sync3_reg & stable_reg;

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      stable_reg <= '0;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      stable_reg <= stable_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode strap

  // Strap is a pin: three flops, a change counts once the last two agree
  // Not reset, since it is static and settles within the reset span
  logic [SYNC_STAGES-1:0] mode_sync_reg;
  logic mode_agree;
  logic dual_reg;

  assign mode_agree = mode_sync_reg[SYNC_STAGES-1] == mode_sync_reg[SYNC_STAGES-2];

  always_ff @(posedge CLK_SYS) begin
    mode_sync_reg <= {mode_sync_reg[SYNC_STAGES-2:0], DUAL_BUS_MODE};
    if (mode_agree) begin
      dual_reg <= mode_sync_reg[SYNC_STAGES-1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded events

  logic [CODE_W-1:0] bus_a;
  logic [CODE_W-1:0] bus_b;
  logic wa_rise;
  logic wb_rise;
  logic wa_fall;
  logic ca_rise;
  logic cb_rise;
  logic sel_a;
  logic pair_rst;

  // Words are unsigned; bit TOP_BIT is the top weight on either bus
  assign bus_a = stable_next[PIN_DA +: CODE_W];
  assign bus_b = stable_next[PIN_DB +: CODE_W];
  // Interleaved mode reuses the A strobe and A clock as the shared pair
  assign wa_rise = rise[PIN_WA];
  assign wb_rise = rise[PIN_WB];
  assign wa_fall = fall[PIN_WA];
  assign ca_rise = rise[PIN_CA];
  assign cb_rise = rise[PIN_CB];
  assign sel_a = stable_reg[PIN_SEL];
  assign pair_rst = stable_next[PIN_RST];

  ////////////////////////////////////////////////////////////////////////////
  // Input latches

  logic [CODE_W-1:0] in_a_reg;
  logic [CODE_W-1:0] in_b_reg;
  logic [CODE_W-1:0] in_a_next;
  logic [CODE_W-1:0] in_b_next;
  logic [CODE_W-1:0] hold_a_reg;
  logic [CODE_W-1:0] hold_b_reg;

  // Dual mode: each bus on its own strobe
  // Interleaved: A bus steered by select; B recirculates while select high
  assign in_a_next = dual_reg ? (wa_rise ? bus_a : in_a_reg) :
                     ((wa_rise && sel_a) ? bus_a : in_a_reg);
  assign in_b_next = dual_reg ? (wb_rise ? bus_b : in_b_reg) :
                     ((wa_rise && !sel_a) ? bus_a : in_b_reg);

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      in_a_reg <= CODE_RESET;
      in_b_reg <= CODE_RESET;
      hold_a_reg <= CODE_RESET;
      hold_b_reg <= CODE_RESET;
    end else begin
      in_a_reg <= in_a_next;
      in_b_reg <= in_b_next;
      if (!dual_reg && wa_fall) begin
        hold_a_reg <= in_a_reg;
        hold_b_reg <= in_b_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divided update clock

  logic div_reg;
  logic div_rise;

  // Pairing reset forces the divider low, fixing which rise pairs the words
  assign div_rise = !dual_reg && ca_rise && !pair_rst && !div_reg;

  always_ff @(posedge CLK_SYS) begin
    if (SRST || dual_reg || pair_rst) begin
      div_reg <= 1'b0;
    end else if (ca_rise) begin
      div_reg <= ~div_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter pipelines

  // Dual mode walks LAT stages on its own clock; interleaved walks half as many
  // on the divided clock, which is the same count of shared input clocks
  logic [CODE_W-1:0] pipe_a_reg [LAT];
  logic [CODE_W-1:0] pipe_b_reg [LAT];
  logic step_a;
  logic step_b;
  logic [CODE_W-1:0] feed_a;
  logic [CODE_W-1:0] feed_b;
  logic [CODE_W-1:0] tap_a;
  logic [CODE_W-1:0] tap_b;

  assign step_a = dual_reg ? ca_rise : div_rise;
  assign step_b = dual_reg ? cb_rise : div_rise;
  assign feed_a = dual_reg ? in_a_reg : hold_a_reg;
  assign feed_b = dual_reg ? in_b_reg : hold_b_reg;
  assign tap_a = dual_reg ? pipe_a_reg[LAT-1] : pipe_a_reg[HALF_LAT-1];
  assign tap_b = dual_reg ? pipe_b_reg[LAT-1] : pipe_b_reg[HALF_LAT-1];

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      for (int i = 0; i < LAT; i++) begin
        pipe_a_reg[i] <= CODE_RESET;
        pipe_b_reg[i] <= CODE_RESET;
      end
    end else begin
      if (step_a) begin
        pipe_a_reg[0] <= feed_a;
        for (int i = 1; i < LAT; i++) begin
          pipe_a_reg[i] <= pipe_a_reg[i-1];
        end
      end
      if (step_b) begin
        pipe_b_reg[0] <= feed_b;
        for (int i = 1; i < LAT; i++) begin
          pipe_b_reg[i] <= pipe_b_reg[i-1];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // One extra system cycle buys registered outputs; latency is still counted in update clocks
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      CODE_A <= CODE_RESET;
      CODE_B <= CODE_RESET;
      UPDATE_A <= 1'b0;
      UPDATE_B <= 1'b0;
      DIV_CLK <= 1'b0;
    end else begin
      CODE_A <= tap_a;
      CODE_B <= tap_b;
      UPDATE_A <= step_a;
      UPDATE_B <= step_b;
      DIV_CLK <= div_reg;
    end
  end

endmodule
`default_nettype wire

// >>> hdl/dda_link_if.sv
// Pin-level link between the sample source and the converter input
`timescale 1ns/1ps
`default_nettype none
interface dda_link_if;
  import dda_pkg::*;
  logic [CODE_W-1:0] chan_a_data;
  logic [CODE_W-1:0] chan_b_data;
  logic chan_a_write_strobe;
  logic chan_b_write_strobe;
  logic chan_a_update_clock;
  logic chan_b_update_clock;
  logic channel_select;
  logic pairing_reset;

  modport dev (
    input chan_a_data,
    input chan_b_data,
    input chan_a_write_strobe,
    input chan_b_write_strobe,
    input chan_a_update_clock,
    input chan_b_update_clock,
    input channel_select,
    input pairing_reset
  );

  modport src (
    output chan_a_data,
    output chan_b_data,
    output chan_a_write_strobe,
    output chan_b_write_strobe,
    output chan_a_update_clock,
    output chan_b_update_clock,
    output channel_select,
    output pairing_reset
  );
endinterface
`default_nettype wire

// >>> hdl/dda_pkg.sv
// Shared constants for the dual converter input link
package dda_pkg;
  // Sample word: straight binary, top bit carries the largest weight
  localparam int CODE_W = 10;
  localparam int TOP_BIT = CODE_W - 1;
  localparam logic [CODE_W-1:0] CODE_RESET = 10'h000;

  // Write strobe to converter output, in update clocks
  localparam int LAT_CLKS = 4;

  // Pin synchroniser depth
  localparam int SYNC_STAGES = 3;

  // Link timing at the system clock
  localparam int SYS_PERIOD_NS = 20;
  localparam int WRT_LAG_MIN_NS = 2;
  localparam int WRT_LAG_MIN_CYC = ((WRT_LAG_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS) < 1 ? 1 :
    ((WRT_LAG_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);
  localparam int LINK_HALF_DEF = 4;
  localparam int FIFO_DEPTH_DEF = 16;

  // Bit positions in the sampled pin vector
  localparam int PIN_WA = 0;
  localparam int PIN_WB = 1;
  localparam int PIN_CA = 2;
  localparam int PIN_CB = 3;
  localparam int PIN_SEL = 4;
  localparam int PIN_RST = 5;
  localparam int PIN_DA = 6;
  localparam int PIN_DB = PIN_DA + CODE_W;
  localparam int PIN_W = PIN_DB + CODE_W;

  // Source sequencer states
  typedef enum logic [1:0] {DDA_ST_IDLE, DDA_ST_PRIME, DDA_ST_RUN} dda_src_state_t;
endpackage

// >>> hdl/dda_src_end.sv
// Sample source: pair FIFO and link sequencer for both bus modes
`timescale 1ns/1ps
`default_nettype none
module dda_fifo #(
  parameter int WIDTH = 2 * dda_pkg::CODE_W,
  parameter int DEPTH = dda_pkg::FIFO_DEPTH_DEF
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("DEPTH must be a power of two, at least 2");
    end
  endgenerate

  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_reg;
  logic [AW:0] rd_reg;
  logic [AW:0] wr_next;
  logic [AW:0] rd_next;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign wr_next = wr_reg + (AW + 1)'(push);
  assign rd_next = rd_reg + (AW + 1)'(pop);
  assign out_data = mem[rd_reg[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_reg[AW-1:0]] <= in_data;
    end
  end

  // Flags come from flops so the source port sees registered ready
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      in_ready <= (wr_next - rd_next) != (AW + 1)'(DEPTH);
      out_valid <= wr_next != rd_next;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////

module dda_src_end #(
  parameter int HALF = dda_pkg::LINK_HALF_DEF,
  parameter int DEPTH = dda_pkg::FIFO_DEPTH_DEF
) (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic DUAL_BUS_MODE,
  input wire logic S_VALID,
  output logic S_READY,
  input wire logic [2*dda_pkg::CODE_W-1:0] S_DATA,
  dda_link_if.src link
);
  import dda_pkg::*;

  generate
    if (HALF < 2) begin : g_bad_half
      $error("HALF must be at least 2 to clear the pin synchroniser");
    end
  endgenerate

  localparam int CW = $clog2(HALF + 1);
  localparam logic [CW-1:0] HALF_M1 = CW'(HALF - 1);

  logic f_valid;
  logic f_ready;
  logic [2*CODE_W-1:0] f_data;

  dda_fifo #(.WIDTH(2 * CODE_W), .DEPTH(DEPTH)) u_fifo (
    .clk(CLK_SYS),
    .srst(SRST),
    .in_valid(S_VALID),
    .in_ready(S_READY),
    .in_data(S_DATA),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Link clock divider

  logic [CW-1:0] cnt_reg;
  logic lclk_reg;
  logic tick;
  logic fall_step;

  assign tick = cnt_reg == HALF_M1;
  assign fall_step = tick && lclk_reg;

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      cnt_reg <= '0;
      lclk_reg <= 1'b0;
    end else begin
      cnt_reg <= tick ? '0 : cnt_reg + CW'(1);
      if (tick) begin
        lclk_reg <= ~lclk_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word sequencer

  dda_src_state_t st_reg;
  logic dual_reg;
  logic phase_b_reg;
  logic [2*CODE_W-1:0] cur_reg;
  logic [CODE_W-1:0] da_reg;
  logic [CODE_W-1:0] db_reg;
  logic sel_reg;
  logic prst_reg;
  logic take;

  // Dual takes a pair every clock; interleaved takes one every second clock
  // Idle step only latches the mode; popping there would lose a pair
  assign take = fall_step && f_valid && (st_reg != DDA_ST_IDLE) && (dual_reg || !phase_b_reg);
  assign f_ready = take;

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      st_reg <= DDA_ST_IDLE;
      dual_reg <= 1'b0;
      phase_b_reg <= 1'b0;
      cur_reg <= '0;
      da_reg <= CODE_RESET;
      db_reg <= CODE_RESET;
      sel_reg <= 1'b1;
      prst_reg <= 1'b1;
    end else if (fall_step) begin
      unique case (st_reg)
        DDA_ST_IDLE: begin
          dual_reg <= DUAL_BUS_MODE;
          st_reg <= DDA_ST_PRIME;
        end
        DDA_ST_PRIME, DDA_ST_RUN: begin
          if (dual_reg) begin
            if (f_valid) begin
              da_reg <= f_data[CODE_W-1:0];
              db_reg <= f_data[2*CODE_W-1:CODE_W];
            end
          end else if (!phase_b_reg) begin
            // A word first, select high
            if (f_valid) begin
              cur_reg <= f_data;
              da_reg <= f_data[CODE_W-1:0];
            end else begin
              da_reg <= cur_reg[CODE_W-1:0];
            end
            sel_reg <= 1'b1;
            phase_b_reg <= 1'b1;
            // First pair already strobed: release so next divided rise takes it
            if (st_reg == DDA_ST_RUN) begin
              prst_reg <= 1'b0;
            end
          end else begin
            da_reg <= cur_reg[2*CODE_W-1:CODE_W];
            sel_reg <= 1'b0;
            phase_b_reg <= 1'b0;
            st_reg <= DDA_ST_RUN;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins

  // Strobe and clock share one source, so edges coincide
  assign link.chan_a_write_strobe = lclk_reg;
  assign link.chan_b_write_strobe = lclk_reg;
  assign link.chan_a_update_clock = lclk_reg;
  assign link.chan_b_update_clock = lclk_reg;
  assign link.chan_a_data = da_reg;
  // B bus idles at zero in interleaved mode: only dual mode loads it
  assign link.chan_b_data = db_reg;
  assign link.channel_select = sel_reg;
  assign link.pairing_reset = prst_reg;
endmodule
`default_nettype wire
